/* File: logic/pwmov_consts.svh */
// register offsets, field positions, reset values for the output override block
`ifndef PWMOV_CONSTS_SVH
`define PWMOV_CONSTS_SVH
`define PWMOV_OFS_OVERRIDE 12'h000
`define PWMOV_OFS_DUTY_ONE 12'h004
`define PWMOV_OFS_DUTY_TWO 12'h008
`define PWMOV_OFS_GEN_WAVE 12'h00c
`define PWMOV_SEL_MSB 15
`define PWMOV_SEL_LSB 8
`define PWMOV_MAN_MSB 7
`define PWMOV_MAN_LSB 0
`define PWMOV_OVERRIDE_RST 16'hff00
`define PWMOV_DUTY_RST 16'h0000
`define PWMOV_WAVE_RST 8'h00
`define PWMOV_ACTIVE_RST 8'hff
`endif

/* File: logic/pwmov_pin_mux.sv */
// per-pin choice between generator waveform and manual output
`timescale 1ns/1ps
module pwmov_pin_mux
  import pwmov_pkg::*;
(
  input wire pwmov_override_t ovr_i,
  input wire logic [7:0] wave_i,
  input wire logic [7:0] active_level_i,
  output logic [7:0] pin_o
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (ovr_i.select[i]) begin
        pin_o[i] = wave_i[i];
      end else begin
        // manual bit one drives active level, zero drives inactive
        pin_o[i] = ovr_i.manual[i] ? active_level_i[i] : ~active_level_i[i];
      end
    end
  end
endmodule // pwmov_pin_mux

/* File: logic/pwmov_pkg.sv */
// types for the output override and duty block
package pwmov_pkg;
  typedef struct packed {
    logic [7:0] select;
    logic [7:0] manual;
  } pwmov_override_t;
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } pwmov_apb_req_t;
  typedef enum logic [1:0] {
    PWMOV_IDLE,
    PWMOV_ACCESS
  } pwmov_state_t;
endpackage

/* File: logic/pwmov_top.sv */
// output override control and first two duty registers with apb slave
// Function
// - select one routes generator waveform to pin
// - select zero routes manual bit to pin
// - manual one drives pin active
// - manual zero drives pin inactive
// - duty one register sixteen bits, resets zero
// - duty two register sixteen bits, resets zero
`timescale 1ns/1ps
`include "pwmov_consts.svh"
module pwmov_top
  import pwmov_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [7:0] gen_wave_i,
  input wire logic [7:0] active_level_i,
  output logic [7:0] pwm_out_o,
  output logic [15:0] duty_value_one_o,
  output logic [15:0] duty_value_two_o
);
  pwmov_override_t override_control;
  logic [15:0] duty_value_one;
  logic [15:0] duty_value_two;
  pwmov_state_t state;
  pwmov_state_t next_state;
  pwmov_apb_req_t apb_req;
  logic [31:0] next_rdata;
  logic next_err;
  logic next_ready;
  logic next_slverr;
  logic [7:0] mux_pins;

  logic access_start;
  logic access_wr;
  logic access_rd;
  logic hit_override;
  logic hit_duty_one;
  logic hit_duty_two;
  logic hit_wave;
  logic hit_none;
  logic wr_override;
  logic wr_duty_one;
  logic wr_duty_two;

  // byte-lane merge shared by the three writable registers; upper lanes carry nothing
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] d,
    input logic [3:0] s
  );
    merge16[7:0] = s[0] ? d[7:0] : old[7:0];
    merge16[15:8] = s[1] ? d[15:8] : old[15:8];
  endfunction

  function automatic logic addr_is(
    input logic [11:0] a,
    input logic [11:0] ofs
  );
    addr_is = (a == ofs);
  endfunction

  function automatic logic [31:0] pad16(
    input logic [15:0] v
  );
    pad16 = {16'h0000, v};
  endfunction

  assign apb_req = {paddr_i, psel_i, penable_i, pwrite_i, pwdata_i};

  // one wait state: answer a cycle after capture so the decode stays registered
  assign access_start = apb_req.psel && apb_req.penable && (state == PWMOV_IDLE);
  assign access_rd = access_start && !apb_req.pwrite;
  // commit in the second access cycle, at the edge where the master sees pready
  assign access_wr = apb_req.psel && apb_req.penable && apb_req.pwrite
                     && (state == PWMOV_ACCESS);

  // every register is one aligned word, so only exact offsets decode
  assign hit_override = addr_is(apb_req.paddr, `PWMOV_OFS_OVERRIDE);
  assign hit_duty_one = addr_is(apb_req.paddr, `PWMOV_OFS_DUTY_ONE);
  assign hit_duty_two = addr_is(apb_req.paddr, `PWMOV_OFS_DUTY_TWO);
  assign hit_wave = addr_is(apb_req.paddr, `PWMOV_OFS_GEN_WAVE);
  assign hit_none = !(hit_override || hit_duty_one || hit_duty_two || hit_wave);

  // the waveform readback has no write path: a write there is dropped without an error
  assign wr_override = access_wr && hit_override;
  assign wr_duty_one = access_wr && hit_duty_one;
  assign wr_duty_two = access_wr && hit_duty_two;

  assign next_ready = access_start;
  assign next_slverr = access_start && next_err;

  always_comb begin
    next_state = state;
    unique case (state)
      PWMOV_IDLE: begin
        if (access_start) begin
          next_state = PWMOV_ACCESS;
        end
      end
      PWMOV_ACCESS: begin
        next_state = PWMOV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= PWMOV_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // bits [15:8] select, [7:0] manual, gen4 high at msb down to gen1 low
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      override_control <= `PWMOV_OVERRIDE_RST;
    end else if (wr_override) begin
      override_control <= merge16(override_control, pwdata_i, pstrb_i);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      duty_value_one <= `PWMOV_DUTY_RST;
    end else if (wr_duty_one) begin
      duty_value_one <= merge16(duty_value_one, pwdata_i, pstrb_i);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      duty_value_two <= `PWMOV_DUTY_RST;
    end else if (wr_duty_two) begin
      duty_value_two <= merge16(duty_value_two, pwdata_i, pstrb_i);
    end
  end

  // unmapped addresses read zero and raise pslverr
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err = hit_none;
    if (hit_override) begin
      next_rdata = pad16(override_control);
    end else if (hit_duty_one) begin
      next_rdata = pad16(duty_value_one);
    end else if (hit_duty_two) begin
      next_rdata = pad16(duty_value_two);
    end else if (hit_wave) begin
      next_rdata = {24'h00_0000, gen_wave_i};
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= next_ready;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pslverr_o <= 1'b0;
    end else begin
      pslverr_o <= next_slverr;
    end
  end

  // read data holds until the next read so a slow master can still take it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (access_rd) begin
      prdata_o <= next_rdata;
    end
  end

  pwmov_pin_mux u_mux (
    .ovr_i(override_control),
    .wave_i(gen_wave_i),
    .active_level_i(active_level_i),
    .pin_o(mux_pins)
  );

  // pins registered so outputs are glitch free toward the switch drivers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwm_out_o <= `PWMOV_WAVE_RST;
    end else begin
      pwm_out_o <= mux_pins;
    end
  end

  // registered copies for the duty comparators outside this block
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      duty_value_one_o <= `PWMOV_DUTY_RST;
    end else begin
      duty_value_one_o <= duty_value_one;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      duty_value_two_o <= `PWMOV_DUTY_RST;
    end else begin
      duty_value_two_o <= duty_value_two;
    end
  end
endmodule // pwmov_top

/* File: verif/pwm_output_override_and_duty_test.sv */
// bench for the override and duty block
`timescale 1ns/1ps
module pwm_output_override_and_duty_test;
  logic clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, r;
  logic [3:0] pstrb_i = 4'hf;
  logic [7:0] gen_wave_i = 0, active_level_i = 8'h0f, pwm_out_o, sn;
  logic [15:0] duty_value_one_o, duty_value_two_o;
  int fails = 0, checks_done = 0, cyc = 0;
  pwmov_top i_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .paddr_i(paddr_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .gen_wave_i(gen_wave_i),
    .active_level_i(active_level_i),
    .pwm_out_o(pwm_out_o),
    .duty_value_one_o(duty_value_one_o),
    .duty_value_two_o(duty_value_two_o)
  );
  pwmov_gate_model i_gm (.pin_i(pwm_out_o), .sense_o(sn));
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 900) begin
      fails++;
      end_of_test();
    end
  end
  task end_of_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, x);
    checks_done++;
    if (g !== x) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask
  // request held until the edge that samples pready high
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    {psel_i, penable_i, paddr_i, pwrite_i, pwdata_i} <= {1'b1, 1'b0, a, w, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    r = prdata_o;
    {psel_i, penable_i} <= 2'b00;
  endtask
  task pin(input logic [15:0] v, input logic [7:0] x);
    apb(12'h000, 1'b1, {16'h0, v});
    repeat (2) @(negedge clk_i);
    chk({24'h0, sn}, {24'h0, x});
  endtask
  task t_regs;
    apb(12'h004, 1'b0, 32'h0);
    chk(r, 32'h0);
    apb(12'h008, 1'b0, 32'h0);
    chk(r, 32'h0);
    apb(12'h004, 1'b1, 32'hffff_a55a);
    apb(12'h008, 1'b1, 32'h0000_8001);
    apb(12'h004, 1'b0, 32'h0);
    chk(r, 32'h0000_a55a);
    apb(12'h008, 1'b0, 32'h0);
    chk(r, 32'h0000_8001);
    pstrb_i <= 4'h2;
    apb(12'h008, 1'b1, 32'h0000_3cff);
    pstrb_i <= 4'hf;
    apb(12'h008, 1'b0, 32'h0);
    chk(r, 32'h0000_3c01);
    chk({16'h0, duty_value_two_o}, 32'h0000_3c01);
    apb(12'h010, 1'b0, 32'h0);
    chk(r, 32'h0);
  endtask
  task t_pins;
    @(posedge clk_i) gen_wave_i <= 8'ha5;
    apb(12'h00c, 1'b0, 32'h0);
    chk(r, 32'h0000_00a5);
    pin(16'hff00, 8'ha5);
    pin(16'h00c3, 8'h33);
    pin(16'hf05a, 8'haa);
    apb(12'h000, 1'b0, 32'h0);
    chk(r, 32'h0000_f05a);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_pins();
    end_of_test();
  end
endmodule // pwm_output_override_and_duty_test
bind pwmov_top pwmov_top_monitor i_mon (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o),
  .paddr_i(paddr_i),
  .pwdata_i(pwdata_i),
  .pstrb_i(pstrb_i),
  .gen_wave_i(gen_wave_i),
  .active_level_i(active_level_i),
  .pwm_out_o(pwm_out_o),
  .duty_value_one_o(duty_value_one_o),
  .duty_value_two_o(duty_value_two_o)
);

/* File: verif/pwmov_gate_model.sv */
// model of the gate drivers fed by the eight pins
`timescale 1ns/1ps
module pwmov_gate_model (
  input wire logic [7:0] pin_i,
  output logic [7:0] sense_o
);
  assign sense_o = pin_i; // ideal driver, no delay
endmodule // pwmov_gate_model

/* File: verif/pwmov_top_monitor.sv */
// checker for the override and duty block
`timescale 1ns/1ps
module pwmov_top_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [7:0] gen_wave_i,
  input wire logic [7:0] active_level_i,
  input wire logic [7:0] pwm_out_o,
  input wire logic [15:0] duty_value_one_o,
  input wire logic [15:0] duty_value_two_o
);
  logic [15:0] ov, pv;
  logic [7:0] px, d;
  logic wr;
  assign wr = pready_o && psel_i && penable_i && pwrite_i && !pslverr_o;
  assign d = pwm_out_o ^ px;
  // shadow of the override register, byte lanes taken as the strobes pick them
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i) ov <= 16'hff00;
    else if (wr && paddr_i == 12'h000) ov <= {pstrb_i[1] ? pwdata_i[15:8] : ov[15:8],
                                              pstrb_i[0] ? pwdata_i[7:0] : ov[7:0]};
  always_ff @(posedge clk_i) begin
    pv <= ov;
    px <= (ov[15:8] & gen_wave_i) | (~ov[15:8] & ~(ov[7:0] ^ active_level_i));
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_gen_path: assert property ((d & pv[15:8]) == 0) else $error("gen");
  a_man_high: assert property ((d & ~pv[15:8] & pv[7:0]) == 0) else $error("on");
  a_man_low: assert property ((d & ~pv[15:8] & ~pv[7:0]) == 0) else $error("off");
  a_ready_next: assert property ($rose(penable_i) && psel_i |=> pready_o) else $error("rdy");
  a_ready_once: assert property (pready_o |=> !pready_o) else $error("pulse");
  a_err_map: assert property (pready_o |->
    pslverr_o == !(paddr_i inside {12'h000, 12'h004, 12'h008, 12'h00c})) else $error("map");
  a_duty_one: assert property (wr && pstrb_i[1:0] == 2'b11 && paddr_i == 12'h004 |-> ##2
    duty_value_one_o == $past(pwdata_i[15:0], 2)) else $error("duty one");
  a_duty_two: assert property (wr && pstrb_i[1:0] == 2'b11 && paddr_i == 12'h008 |-> ##2
    duty_value_two_o == $past(pwdata_i[15:0], 2)) else $error("duty two");
  cover property (wr);
  cover property (pready_o && pslverr_o);
  cover property (d == 0 && pv == 16'hf05a);
  cover property (d == 0 && pv == 16'h00c3);
endmodule // pwmov_top_monitor
